//--- src/epd_port_map.vh
// timing counts, widths and codes for the serial write port
`ifndef EPD_PORT_MAP_VH
`define EPD_PORT_MAP_VH
// -----------------------------------------------------------------------------
// framing
// -----------------------------------------------------------------------------
`define EPD_BYTE_BITS        4'h8
`define EPD_FRAME4_LAST      4'h7
`define EPD_FRAME3_LAST      4'h8
`define EPD_MODE_FOUR_WIRE   1'b0
`define EPD_MODE_THREE_WIRE  1'b1
`define EPD_KIND_COMMAND     1'b0
`define EPD_KIND_DATA        1'b1
// -----------------------------------------------------------------------------
// buffering and reset values
// -----------------------------------------------------------------------------
`define EPD_FIFO_WIDTH       9
`define EPD_FIFO_DEPTH       16
`define EPD_FIFO_ADDR        4
`define EPD_RST_COUNT        4'h0
`define EPD_RST_SHIFT        9'h000
`define EPD_RST_SYNC         3'h7
`endif

//--- src/epd_word_fifo.v
// synchronous fifo holding received command or data words
module epd_word_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             i_ref_clk,
  input  wire             i_reset_n,
  // filling side
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_in_ready,
  // draining side
  output wire             o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      level;
  wire            push;
  wire            pop;

  assign o_in_ready  = (level != DEPTH);
  assign o_out_valid = (level != 0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // storage written only on an accepted push
  always @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // pointers and fill level
  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule // epd_word_fifo

//--- src/epd_serial_write_port.v
// serial write port: frames host bytes into command or data words
// Behaviour
// - Traffic is accepted only while chip_select_n is low.
// - Four-wire: data_command_select high means data, low means command.
// - Busy output high during waveform, memory programming or sensor traffic.
// - interface_select low gives four-wire, high gives three-wire nine-bit frames.
// - Three-wire mode ignores data_command_select; host ties it low.
// - Four-wire: shift serial_in on rising clock edges, D7 first.
// - Four-wire: sample select on eighth clock and write byte then.
// - Three-wire: nine bits, kind bit first, frame ends on ninth clock.
// - Three-wire: leading one routes byte to RAM, zero to command register.
// - Write only; no read path back to the host.
// - Clock pin is shift clock, data pin is serial input.
// - Low on hardware reset input resets the port.
`include "epd_port_map.vh"
module epd_serial_write_port (
  // clock and reset
  input  wire       i_ref_clk,
  input  wire       i_reset_n,
  // host pins
  input  wire       i_chip_select_n,
  input  wire       i_serial_shift_clock,
  input  wire       i_serial_in,
  input  wire       i_data_command_select,
  input  wire       i_interface_select,
  // internal activity sources
  input  wire       i_waveform_active,
  input  wire       i_otp_program_active,
  input  wire       i_sensor_active,
  // received word stream
  output reg        o_word_valid,
  output reg  [7:0] o_word_byte,
  output reg        o_word_is_data,
  input  wire       i_word_ready,
  // status
  output reg        o_operation_in_progress,
  output reg        o_frame_dropped
);
  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  reg [2:0] sync_cs;
  reg [2:0] sync_clk;
  reg [2:0] sync_din;
  reg [2:0] sync_dc;
  reg [2:0] sync_bs;
  // framing state
  reg       cs_active;
  reg       clk_level;
  reg       mode;
  reg [3:0] bit_count;
  reg [8:0] shift;
  reg       fifo_in_valid;
  reg [8:0] fifo_in_data;
  reg       next_in_valid;
  reg [8:0] next_in_data;
  wire      fifo_in_ready;
  wire      fifo_out_valid;
  wire [8:0] fifo_out_data;
  wire      out_take;
  wire      clk_rise;
  wire [3:0] last_bit;

  // three stages each; a select, clock or strap change counts once stages two and three agree
  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      sync_cs  <= `EPD_RST_SYNC;
      sync_clk <= 3'h0;
      sync_din <= 3'h0;
      sync_dc  <= 3'h0;
      sync_bs  <= 3'h0;
    end else begin
      sync_cs  <= {sync_cs[1:0], i_chip_select_n};
      sync_clk <= {sync_clk[1:0], i_serial_shift_clock};
      sync_din <= {sync_din[1:0], i_serial_in};
      sync_dc  <= {sync_dc[1:0], i_data_command_select};
      sync_bs  <= {sync_bs[1:0], i_interface_select};
    end
  end

  // a select or clock pulse shorter than two cycles never reaches the framing logic
  // filtered levels for select and clock
  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      cs_active <= 1'b0;
      clk_level <= 1'b0;
    end else begin
      if (sync_cs[1] == sync_cs[2]) begin
        cs_active <= ~sync_cs[2];
      end
      if (sync_clk[1] == sync_clk[2]) begin
        clk_level <= sync_clk[2];
      end
    end
  end

  // one-cycle pulse on a settled rise of the shift clock
  assign clk_rise = (sync_clk[1] == sync_clk[2]) & sync_clk[2] & ~clk_level;
  // frame length follows the strap
  // nine-bit frames close on count eight, eight-bit frames on count seven
  assign last_bit = (mode == `EPD_MODE_THREE_WIRE) ? `EPD_FRAME3_LAST
                                                   : `EPD_FRAME4_LAST;

  // ---------------------------------------------------------------------------
  // strap capture and frame assembly
  // ---------------------------------------------------------------------------
  // strap is caught in idle gaps only, so a frame never changes length midway
  // the strap is a pin as well, so it is filtered like the others
  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      mode <= `EPD_MODE_FOUR_WIRE;
    end else if (!cs_active && sync_bs[1] == sync_bs[2]) begin
      mode <= sync_bs[2];
    end
  end

  // shifter and bit counter; released select drops a partial frame
  // limitation: a shift clock edge within about one cycle of a select edge may be lost
  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      bit_count       <= `EPD_RST_COUNT;
      shift           <= `EPD_RST_SHIFT;
      o_frame_dropped <= 1'b0;
    end else begin
      o_frame_dropped <= 1'b0;
      if (!cs_active) begin
        if (bit_count != `EPD_RST_COUNT) begin
          o_frame_dropped <= 1'b1;
        end
        bit_count <= `EPD_RST_COUNT;
      end else if (clk_rise) begin
        shift <= {shift[7:0], sync_din[2]};
        if (bit_count == last_bit) begin
          bit_count <= `EPD_RST_COUNT;
        end else begin
          bit_count <= bit_count + 4'h1;
        end
      end
    end
  end

  // word to push when the last bit of a frame arrives
  always @* begin
    next_in_valid = 1'b0;
    next_in_data  = {1'b0, shift[6:0], sync_din[2]};
    if (cs_active && clk_rise && bit_count == last_bit) begin
      next_in_valid = 1'b1;
      if (mode == `EPD_MODE_THREE_WIRE) begin
        next_in_data = {shift[7:0], sync_din[2]};
      end else begin
        next_in_data = {sync_dc[2], shift[6:0], sync_din[2]};
      end
    end
  end

  // one-word holding stage; host pacing keeps it far below the frame rate
  // a word arriving while the holding stage is still full and the fifo is full overwrites the held word, which is lost
  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      fifo_in_valid <= 1'b0;
      fifo_in_data  <= `EPD_RST_SHIFT;
    end else if (next_in_valid) begin
      fifo_in_valid <= 1'b1;
      fifo_in_data  <= next_in_data;
    end else if (fifo_in_ready) begin
      fifo_in_valid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // word buffer and output stage
  // ---------------------------------------------------------------------------
  // sixteen words absorb bursts while the consumer stalls
  epd_word_fifo #(
    .WIDTH (`EPD_FIFO_WIDTH),
    .DEPTH (`EPD_FIFO_DEPTH),
    .AW    (`EPD_FIFO_ADDR)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (fifo_in_valid),
    .i_in_data   (fifo_in_data),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (out_take)
  );

  // registered output slot refilled whenever empty or consumed
  // trade-off: one more cycle of latency keeps every output straight from a flop
  assign out_take = fifo_out_valid & (~o_word_valid | i_word_ready);

  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_word_valid   <= 1'b0;
      o_word_byte    <= 8'h00;
      o_word_is_data <= `EPD_KIND_COMMAND;
    end else if (out_take) begin
      o_word_valid   <= 1'b1;
      o_word_byte    <= fifo_out_data[7:0];
      o_word_is_data <= fifo_out_data[8];
    end else if (i_word_ready) begin
      o_word_valid   <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // status
  // ---------------------------------------------------------------------------
  // busy flag for any long internal operation
  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_operation_in_progress <= 1'b0;
    end else begin
      o_operation_in_progress <= i_waveform_active | i_otp_program_active
                                 | i_sensor_active;
    end
  end
endmodule // epd_serial_write_port

//--- test/epd_port_props.sv
// concurrent checks on the serial write port pins
module epd_port_props (
  input wire       i_ref_clk,
  input wire       i_reset_n,
  input wire       i_chip_select_n,
  input wire       i_waveform_active,
  input wire       i_otp_program_active,
  input wire       i_sensor_active,
  input wire       o_word_valid,
  input wire [7:0] o_word_byte,
  input wire       o_word_is_data,
  input wire       i_word_ready,
  input wire       o_operation_in_progress,
  input wire       o_frame_dropped
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  wire any_act = i_waveform_active | i_otp_program_active | i_sensor_active;
  a_busy_follow: assert property ($past(i_reset_n) |->
    o_operation_in_progress == $past(any_act)) else $error("busy not one cycle behind");
  a_busy_clear: assert property (!any_act [*2] |-> !o_operation_in_progress)
    else $error("busy without activity");
  a_busy_otp: assert property (i_otp_program_active ##1 i_otp_program_active
    |-> o_operation_in_progress) else $error("busy missing in programming");
  a_reset_quiet: assert property (disable iff (1'b0) !i_reset_n |=>
    !o_word_valid && !o_operation_in_progress && !o_frame_dropped) else $error("reset leak");
  a_reset_start: assert property ($rose(i_reset_n) |-> !o_word_valid [*3])
    else $error("word right after reset");
  a_word_hold: assert property (o_word_valid && !i_word_ready |=> o_word_valid &&
    $stable(o_word_byte) && $stable(o_word_is_data)) else $error("word not held");
  a_drop_pulse: assert property (o_frame_dropped |=> !o_frame_dropped)
    else $error("drop pulse too long");
  a_idle_no_drop: assert property (i_chip_select_n [*8] |-> !o_frame_dropped)
    else $error("drop while idle");
  // main scenarios reached
  cover property (o_frame_dropped);
  cover property (o_word_valid && o_word_is_data && i_word_ready);
  cover property (o_word_valid && !i_word_ready);
endmodule // epd_port_props

//--- test/epd_host_model.sv
// host controller model driving the serial write pins
module epd_host_model (
  input  wire  i_ref_clk,
  input  wire  i_operation_in_progress,
  output logic o_chip_select_n,
  output logic o_serial_shift_clock,
  output logic o_serial_in,
  output logic o_data_command_select
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle pins: select high, clock parked low
  initial begin
    o_chip_select_n = 1'b1;
    o_serial_shift_clock = 1'b0;
    o_serial_in = 1'b0;
    o_data_command_select = 1'b0;
  end
  // n shift clocks of one frame; halves of 4 cycles give the 160 ns link period
  task automatic frame(input logic three, input logic kind, input logic [7:0] b, input int n);
    logic [8:0] w;
    int         s;
    w = {kind, b};
    s = three ? 8 : 7;
    while (i_operation_in_progress !== 1'b0) @(posedge i_ref_clk);
    @(posedge i_ref_clk);
    o_chip_select_n <= 1'b0;
    o_data_command_select <= three ? 1'b0 : kind;
    for (int i = 0; i < n; i++) begin
      o_serial_in <= w[s-i];
      repeat (4) @(posedge i_ref_clk);
      o_serial_shift_clock <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      o_serial_shift_clock <= 1'b0;
    end
    repeat (4) @(posedge i_ref_clk);
    o_chip_select_n <= 1'b1;
    o_serial_in <= ~o_serial_in; // released line must not keep the last bit
    repeat (8) @(posedge i_ref_clk);
  endtask
  // shift clocks with the select released; the port must ignore them
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge i_ref_clk);
      o_serial_shift_clock <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      o_serial_shift_clock <= 1'b0;
    end
    repeat (8) @(posedge i_ref_clk);
  endtask
endmodule // epd_host_model

//--- test/epd_serial_write_port_tb.sv
// self-checking bench for the serial write port
module epd_serial_write_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk, i_reset_n, i_chip_select_n, i_serial_shift_clock, i_serial_in;
  logic i_data_command_select, i_interface_select, i_word_ready;
  logic i_waveform_active, i_otp_program_active, i_sensor_active;
  wire  o_word_valid, o_word_is_data, o_operation_in_progress, o_frame_dropped;
  wire  [7:0] o_word_byte;
  logic [8:0] got[$], exp[$];
  int   fails = 0, n_tests = 0, drops = 0;
  epd_serial_write_port u_epd_serial_write_port (.i_ref_clk, .i_reset_n, .i_chip_select_n,
    .i_serial_shift_clock, .i_serial_in, .i_data_command_select, .i_interface_select,
    .i_waveform_active, .i_otp_program_active, .i_sensor_active, .o_word_valid,
    .o_word_byte, .o_word_is_data, .i_word_ready, .o_operation_in_progress, .o_frame_dropped);
  epd_host_model u_epd_host_model (.i_ref_clk, .i_operation_in_progress(o_operation_in_progress),
    .o_chip_select_n(i_chip_select_n), .o_serial_shift_clock(i_serial_shift_clock),
    .o_serial_in(i_serial_in), .o_data_command_select(i_data_command_select));
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  // collect accepted words and drop pulses
  always @(posedge i_ref_clk) begin
    if (i_reset_n && o_word_valid === 1'b1 && i_word_ready) got.push_back({o_word_is_data, o_word_byte});
    if (o_frame_dropped === 1'b1) drops++;
  end
  task automatic check(input string what, input logic [8:0] e, input logic [8:0] s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic xfer(input logic kind, input logic [7:0] b);
    u_epd_host_model.frame(i_interface_select, kind, b, i_interface_select ? 9 : 8);
    exp.push_back({kind, b});
  endtask
  // bounded wait for every word, then compare in order
  task automatic drain(input string name);
    int k;
    k = 0;
    while (got.size() < exp.size() && k < 400) begin
      @(posedge i_ref_clk);
      k++;
    end
    check("word count", 9'(exp.size()), 9'(got.size()));
    while (exp.size() > 0 && got.size() > 0) check("word", exp.pop_front(), got.pop_front());
    exp.delete();
    got.delete();
    $display("test %s done", name);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard, well beyond the roughly 38 us the tests need
  initial begin
    #300us;
    fails++;
    print_verdict();
  end
  initial begin
    i_reset_n <= 1'b0;
    i_interface_select <= 1'b0;
    i_word_ready <= 1'b1;
    {i_waveform_active, i_otp_program_active, i_sensor_active} <= 3'h0;
    repeat (2) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    repeat (10) @(posedge i_ref_clk);
    xfer(1'b0, 8'ha5);
    xfer(1'b1, 8'h3c);
    drain("four_wire");
    i_interface_select <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    xfer(1'b1, 8'h81);
    xfer(1'b0, 8'h7e);
    drain("three_wire");
    u_epd_host_model.frame(1'b1, 1'b1, 8'hff, 5);
    u_epd_host_model.stray(9);
    xfer(1'b1, 8'h5a);
    drain("abort");
    check("drops", 9'h001, 9'(drops));
    // consumer stalls while 17 words queue up, then drains them all
    i_interface_select <= 1'b0;
    i_word_ready <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    for (int i = 0; i < 17; i++) xfer(i[0], 8'(i * 13));
    i_word_ready <= 1'b1;
    drain("stall");
    for (int i = 0; i < 4; i++) begin
      {i_waveform_active, i_otp_program_active, i_sensor_active} <= 3'(1 << i);
      repeat (3) @(posedge i_ref_clk);
      check("busy", {8'h00, i < 3}, 9'(o_operation_in_progress));
    end
    $display("test busy done");
    print_verdict();
  end
endmodule // epd_serial_write_port_tb
bind epd_serial_write_port epd_port_props u_epd_port_props (.i_ref_clk, .i_reset_n,
  .i_chip_select_n, .i_waveform_active, .i_otp_program_active, .i_sensor_active,
  .o_word_valid, .o_word_byte, .o_word_is_data, .i_word_ready, .o_operation_in_progress,
  .o_frame_dropped);
